// File: common/atef_pkg.sv
// constants, types and helpers for the timer event-flag block
package atef_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ATEF_OFF_CTRL   = 8'h00;
  localparam logic [7:0] ATEF_OFF_STATUS = 8'h10;
  localparam logic [7:0] ATEF_OFF_SWEVT  = 8'h14;
  localparam logic [7:0] ATEF_OFF_CM1    = 8'h18;
  localparam logic [7:0] ATEF_OFF_CM2    = 8'h1C;
  localparam logic [7:0] ATEF_OFF_C1DT   = 8'h34;

  localparam logic [1:0] ATEF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ATEF_RESP_SLVERR = 2'h2;

  localparam logic [15:0] ATEF_RESET_16 = 16'h0000;
  localparam logic [7:0]  ATEF_RESET_8  = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ATEF_CTRL_OVF_DIS  = 0;
  localparam int ATEF_CTRL_OVF_SRC  = 1;
  localparam int ATEF_CTRL_SUSPEND  = 2;
  localparam int ATEF_CTRL_REINIT   = 3;
  localparam int ATEF_CTRL_TRG_FALL = 4;
  localparam logic [15:0] ATEF_CTRL_MASK = 16'h001F;

  localparam int ATEF_EV_OVF  = 0;
  localparam int ATEF_EV_CH1  = 1;
  localparam int ATEF_EV_HALL = 5;
  localparam int ATEF_EV_TRG  = 6;
  localparam int ATEF_EV_BRK  = 7;

  localparam int ATEF_CM_SLOT  = 8;
  localparam int ATEF_CM_DIR_W = 2;
  localparam int ATEF_CM_OCTRL = 4;
  localparam int ATEF_CM_IFILT = 4;

  // channels with a complementary output
  localparam logic [3:0] ATEF_COMP_MASK = 4'h7;

  typedef enum logic [1:0] {
    ATEF_DIR_OUTPUT = 2'b00,
    ATEF_DIR_IN_A   = 2'b01,
    ATEF_DIR_IN_B   = 2'b10,
    ATEF_DIR_IN_C   = 2'b11
  } atef_dir_t;

  // ****************************************************************
  // byte-lane merge for 16-bit registers
  // ****************************************************************
  function automatic logic [15:0] atef_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [1:0] strb);
    atef_merge = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : atef_merge

endpackage : atef_pkg

// File: core/atef_timer_events.sv
// event flags, software events and channel direction decode of the timer
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module atef_timer_events
  import atef_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        trigger_input,
  input  wire logic        break_input,
  input  wire logic        counter_overflow,
  input  wire logic [3:0]  capture_event,
  input  wire logic [3:0]  compare_event,
  input  wire logic [15:0] capture_value,
  output logic             break_event,
  output logic             trigger_event,
  output logic             hall_event,
  output logic             overflow_event,
  output logic [3:0]       chan_event,
  output logic [3:0]       hall_update,
  output logic             counter_reinit,
  output logic [3:0]       chan_is_input,
  output logic [11:0]      chan_out_ctrl,
  output logic [15:0]      chan_in_filter,
  output logic [15:0]      chan1_compare_value,
  output logic [7:0]       status_flags
);

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic        aw_full_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;
  logic        ar_take;
  logic        rd_swevt_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] cm_reg [2];
  logic [15:0] c1dt_reg;
  logic [7:0]  flags_reg;
  logic        trig_prev_reg;

  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign ar_take  = s_axi_arvalid && s_axi_arready;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ATEF_OFF_CTRL) || (a == ATEF_OFF_STATUS) || (a == ATEF_OFF_SWEVT) ||
             (a == ATEF_OFF_CM1) || (a == ATEF_OFF_CM2) || (a == ATEF_OFF_C1DT);
  endfunction : mapped

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      aw_addr_reg   <= ATEF_RESET_8;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg   <= 1'b0;
      w_data_reg   <= {ATEF_RESET_16, ATEF_RESET_16};
      w_strb_reg   <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ATEF_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr_reg) ? ATEF_RESP_OKAY : ATEF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= {ATEF_RESET_16, ATEF_RESET_16};
      s_axi_rresp   <= ATEF_RESP_OKAY;
      rd_swevt_reg  <= 1'b0;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? ATEF_RESP_OKAY : ATEF_RESP_SLVERR;
      rd_swevt_reg  <= (s_axi_araddr == ATEF_OFF_SWEVT);
      case (s_axi_araddr)
        ATEF_OFF_CTRL:   s_axi_rdata <= {ATEF_RESET_16, ctrl_reg};
        ATEF_OFF_STATUS: s_axi_rdata <= {ATEF_RESET_16, ATEF_RESET_8, flags_reg};
        ATEF_OFF_CM1:    s_axi_rdata <= {ATEF_RESET_16, cm_reg[0]};
        ATEF_OFF_CM2:    s_axi_rdata <= {ATEF_RESET_16, cm_reg[1]};
        ATEF_OFF_C1DT:   s_axi_rdata <= {ATEF_RESET_16, c1dt_reg};
        // request bits have already fired, so they read back as zero
        default:         s_axi_rdata <= {ATEF_RESET_16, ATEF_RESET_16};
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic wr_ctrl;
  logic wr_status;
  logic wr_swevt;
  logic wr_c1dt;
  logic rd_c1dt;

  assign wr_ctrl   = do_write && (aw_addr_reg == ATEF_OFF_CTRL);
  assign wr_status = do_write && (aw_addr_reg == ATEF_OFF_STATUS);
  assign wr_swevt  = do_write && (aw_addr_reg == ATEF_OFF_SWEVT);
  assign wr_c1dt   = do_write && (aw_addr_reg == ATEF_OFF_C1DT);
  assign rd_c1dt   = ar_take && (s_axi_araddr == ATEF_OFF_C1DT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= ATEF_RESET_16;
    end else if (wr_ctrl) begin
      ctrl_reg <= atef_merge(ctrl_reg, w_data_reg[15:0], w_strb_reg[1:0]) & ATEF_CTRL_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cm_reg[0] <= ATEF_RESET_16;
      cm_reg[1] <= ATEF_RESET_16;
    end else if (do_write && (aw_addr_reg == ATEF_OFF_CM1)) begin
      cm_reg[0] <= atef_merge(cm_reg[0], w_data_reg[15:0], w_strb_reg[1:0]);
    end else if (do_write && (aw_addr_reg == ATEF_OFF_CM2)) begin
      cm_reg[1] <= atef_merge(cm_reg[1], w_data_reg[15:0], w_strb_reg[1:0]);
    end
  end

  // ****************************************************************
  // event generation
  // ****************************************************************
  logic [3:0] is_in;
  logic [7:0] sw_req;
  logic       trig_rise;
  logic       trig_fall;
  logic       trig_evt;
  logic       reinit_evt;
  logic       ovf_evt;
  logic       ovf_dis;
  logic       ovf_src;
  logic [3:0] chan_set;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_dir
      atef_dir_t dir;
      assign dir = atef_dir_t'(cm_reg[gi / 2][(gi % 2) * ATEF_CM_SLOT +: ATEF_CM_DIR_W]);
      assign is_in[gi] = (dir != ATEF_DIR_OUTPUT);
      assign chan_set[gi] = (is_in[gi] ? capture_event[gi] : compare_event[gi]) | sw_req[ATEF_EV_CH1 + gi];
    end
  endgenerate

  // only lane 0 is taken; the upper byte is reserved and kept zero by software
  assign sw_req = (wr_swevt && w_strb_reg[0]) ? w_data_reg[7:0] : ATEF_RESET_8;

  assign ovf_dis   = ctrl_reg[ATEF_CTRL_OVF_DIS];
  assign ovf_src   = ctrl_reg[ATEF_CTRL_OVF_SRC];
  assign trig_rise = trigger_input && !trig_prev_reg;
  assign trig_fall = !trigger_input && trig_prev_reg;
  assign trig_evt  = (ctrl_reg[ATEF_CTRL_SUSPEND] ? (trig_rise | trig_fall)
                      : (ctrl_reg[ATEF_CTRL_TRG_FALL] ? trig_fall : trig_rise))
                     | sw_req[ATEF_EV_TRG];
  assign reinit_evt = trig_evt && ctrl_reg[ATEF_CTRL_REINIT];
  assign ovf_evt   = !ovf_dis && (counter_overflow
                     || (!ovf_src && (sw_req[ATEF_EV_OVF]
                     || reinit_evt)));

  // follows the pin through reset too, so a high idle level gives no false edge
  always_ff @(posedge aclk) begin
    trig_prev_reg <= trigger_input;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_event    <= 1'b0;
      trigger_event  <= 1'b0;
      hall_event     <= 1'b0;
      overflow_event <= 1'b0;
      chan_event     <= 4'h0;
      hall_update    <= 4'h0;
      counter_reinit <= 1'b0;
    end else begin
      break_event    <= sw_req[ATEF_EV_BRK] | break_input;
      trigger_event  <= trig_evt;
      hall_event     <= sw_req[ATEF_EV_HALL];
      overflow_event <= ovf_evt;
      chan_event     <= chan_set;
      hall_update    <= sw_req[ATEF_EV_HALL] ? ATEF_COMP_MASK : 4'h0;
      counter_reinit <= reinit_evt;
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  assign flag_set = {break_input | sw_req[ATEF_EV_BRK], trig_evt, sw_req[ATEF_EV_HALL],
                     chan_set, ovf_evt};

  always_comb begin
    flag_clr = ATEF_RESET_8;
    if (wr_status && w_strb_reg[0]) begin
      flag_clr = ~w_data_reg[7:0];
    end
    // data read only clears the flag of a capturing channel
    if (rd_c1dt && is_in[0]) begin
      flag_clr[ATEF_EV_CH1] = 1'b1;
    end
  end

  // a new event in the clearing cycle keeps its flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= ATEF_RESET_8;
    end else begin
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c1dt_reg <= ATEF_RESET_16;
    end else if (is_in[0] && capture_event[0]) begin
      c1dt_reg <= capture_value;
    end else if (wr_c1dt && !is_in[0]) begin
      c1dt_reg <= atef_merge(c1dt_reg, w_data_reg[15:0], w_strb_reg[1:0]);
    end
  end

  // ****************************************************************
  // channel mode decode
  // ****************************************************************
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mode
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          chan_is_input[gi]            <= 1'b0;
          chan_out_ctrl[gi * 3 +: 3]   <= 3'h0;
          chan_in_filter[gi * 4 +: 4]  <= 4'h0;
        end else begin
          chan_is_input[gi] <= is_in[gi];
          // the same bits read as compare control or as input filter
          chan_out_ctrl[gi * 3 +: 3] <= is_in[gi] ? 3'h0
                                        : cm_reg[gi / 2][(gi % 2) * ATEF_CM_SLOT + ATEF_CM_OCTRL +: 3];
          chan_in_filter[gi * 4 +: 4] <= is_in[gi]
                                        ? cm_reg[gi / 2][(gi % 2) * ATEF_CM_SLOT + ATEF_CM_IFILT +: 4]
                                        : 4'h0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan1_compare_value <= ATEF_RESET_16;
      status_flags        <= ATEF_RESET_8;
    end else begin
      chan1_compare_value <= c1dt_reg;
      status_flags        <= (flags_reg & ~flag_clr) | flag_set;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_ovf_sw_event: assert property (@(posedge aclk) disable iff (!aresetn)
    (sw_req[ATEF_EV_OVF] && !ovf_dis && !ovf_src) |=> overflow_event ##1 !overflow_event || $past(ovf_evt))
    else $error("software overflow request gave no overflow event");

  a_trig_reinit: assert property (@(posedge aclk) disable iff (!aresetn)
    (trig_evt && ctrl_reg[ATEF_CTRL_REINIT] && !ovf_dis && !ovf_src) |=> (overflow_event && counter_reinit))
    else $error("trigger reinit gave no overflow event");

  a_ovf_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (flags_reg[ATEF_EV_OVF] && !flag_clr[ATEF_EV_OVF]) || ovf_evt |=> flags_reg[ATEF_EV_OVF])
    else $error("overflow flag lost without a clear");

  a_c1_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_in[0] && capture_event[0]) |=> (flags_reg[ATEF_EV_CH1] && c1dt_reg == $past(capture_value)))
    else $error("capture did not set channel 1 flag and data");

  a_c1_read_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_c1dt && is_in[0] && !flag_set[ATEF_EV_CH1]) |=> !flags_reg[ATEF_EV_CH1])
    else $error("data read did not clear channel 1 flag");

  a_c1_out_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (!is_in[0] && flags_reg[ATEF_EV_CH1] && !(wr_status && w_strb_reg[0])) |=> flags_reg[ATEF_EV_CH1])
    else $error("output-mode channel 1 flag cleared without software");

  a_zero_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_status && w_strb_reg[0] && !w_data_reg[ATEF_EV_OVF] && !ovf_evt) |=> !flags_reg[ATEF_EV_OVF])
    else $error("writing zero did not clear the overflow flag");

  a_break_sw: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_req[ATEF_EV_BRK] |=> (break_event && flags_reg[ATEF_EV_BRK]))
    else $error("software break request lost");

  a_hall_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    hall_update == (hall_event ? ATEF_COMP_MASK : 4'h0))
    else $error("hall update reached a channel without complementary output");

  a_suspend_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_reg[ATEF_CTRL_SUSPEND] && trigger_input != trig_prev_reg) |=> trigger_event)
    else $error("edge in suspend mode gave no trigger event");

  a_swevt_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && rd_swevt_reg) |-> (s_axi_rdata == {ATEF_RESET_16, ATEF_RESET_16}))
    else $error("software event register read back nonzero");

  a_out_ctrl_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    (chan_out_ctrl[2:0] != 3'h0) |-> (!chan_is_input[0] && chan_in_filter[3:0] == 4'h0))
    else $error("output control shown while channel 1 captures");

endmodule : atef_timer_events

`default_nettype wire

// File: tb/atef_timer_events_tb_top.sv
// self-checking testbench of the timer event-flag block
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module atef_timer_events_tb_top
  import atef_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        trg_in, brk_in, cnt_ovf;
  logic [3:0]  cap_ev, cmp_ev;
  logic [15:0] cap_val;
  logic        brk_ev, trg_ev, hall_ev, ovf_ev, reinit;
  logic [3:0]  ch_ev, hall_upd, is_in;
  logic [11:0] out_ctrl;
  logic [15:0] in_filt, c1_cmp;
  logic [7:0]  flags;
  logic [8:0]  seen;
  logic [3:0]  hall_seen;
  logic        seen_clr;
  logic [31:0] rd;
  logic [1:0]  rs, ws;
  int          mismatches = 0;
  int          compares = 0;

  always #20 aclk = ~aclk;

  atef_timer_events dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trigger_input(trg_in), .break_input(brk_in), .counter_overflow(cnt_ovf), .capture_event(cap_ev),
    .compare_event(cmp_ev), .capture_value(cap_val), .break_event(brk_ev), .trigger_event(trg_ev),
    .hall_event(hall_ev), .overflow_event(ovf_ev), .chan_event(ch_ev), .hall_update(hall_upd),
    .counter_reinit(reinit), .chan_is_input(is_in), .chan_out_ctrl(out_ctrl), .chan_in_filter(in_filt),
    .chan1_compare_value(c1_cmp), .status_flags(flags)
  );

  // ****************************************************************
  // event pulse collector
  // ****************************************************************
  always @(posedge aclk) begin
    if (seen_clr || !aresetn) begin
      seen      <= '0;
      hall_seen <= '0;
    end else begin
      seen      <= seen | {reinit, brk_ev, trg_ev, hall_ev, ovf_ev, ch_ev};
      hall_seen <= hall_seen | hall_upd;
    end
  end

  // ****************************************************************
  // bus and helper tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic timed_out();
    mismatches++;
    $display("[ERR] %0t bus wait ran out", $time);
    give_verdict();
  endtask : timed_out

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    int n;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (!aw_ok && awvalid && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wvalid && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        ws = bresp;
        break;
      end
    end
    if (n == 50) timed_out();
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    bit ar_ok;
    int n;
    ar_ok = 0;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (!ar_ok && arready) begin
        ar_ok = 1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        break;
      end
    end
    if (n == 50) timed_out();
  endtask : rdr

  task automatic clr_seen();
    seen_clr <= 1'b1;
    @(posedge aclk);
    seen_clr <= 1'b0;
  endtask : clr_seen

  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask : settle

  // one-cycle pulse: 0 counter overflow, 1 capture ch1, 2 compare ch1, else break pin
  task automatic pulse(input int which);
    case (which)
      0: cnt_ovf <= 1'b1;
      1: cap_ev <= 4'h1;
      2: cmp_ev <= 4'h1;
      default: brk_in <= 1'b1;
    endcase
    @(posedge aclk);
    cnt_ovf <= 1'b0;
    cap_ev <= 4'h0;
    cmp_ev <= 4'h0;
    brk_in <= 1'b0;
    settle();
  endtask : pulse

  function automatic logic [8:0] ev_of(input int i);
    logic [8:0] e;
    e = '0;
    if (i == 0) e[4] = 1'b1;
    else if (i < 5) e[i-1] = 1'b1;
    else e[i] = 1'b1;
    return e;
  endfunction : ev_of

  // ****************************************************************
  // main sequence
  // ****************************************************************
  logic [4:0] tctl [6] = '{5'h00, 5'h00, 5'h04, 5'h04, 5'h10, 5'h10};
  logic       tlvl [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic       texp [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; bready = 1'b1; rready = 1'b1;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'h3; trg_in = 1'b0; brk_in = 1'b0; cnt_ovf = 1'b0;
    cap_ev = '0; cmp_ev = '0; cap_val = '0; seen_clr = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(awready, 1'b1)
    rdr(ATEF_OFF_STATUS); `CHK(rd, 32'h0000_0000)
    `CHK(rs, ATEF_RESP_OKAY)
    rdr(8'h40); `CHK(rs, ATEF_RESP_SLVERR)
    `CHK(rd, 32'h0000_0000)
    wr(8'h40, 32'h0000_00FF); `CHK(ws, ATEF_RESP_SLVERR)
    $display("test reset and map done");
    for (int i = 0; i < 8; i++) begin
      wr(ATEF_OFF_STATUS, 32'h0000_0000);
      clr_seen();
      wr(ATEF_OFF_SWEVT, 32'h1 << i);
      settle();
      `CHK(seen, ev_of(i))
      `CHK(hall_seen, (i == 5) ? 4'b0111 : 4'b0000)
      rdr(ATEF_OFF_STATUS); `CHK(rd, 32'h1 << i)
      rdr(ATEF_OFF_SWEVT); `CHK(rd, 32'h0000_0000)
    end
    wr(ATEF_OFF_STATUS, 32'h0000_00FF);
    rdr(ATEF_OFF_STATUS); `CHK(rd, 32'h0000_0080)
    wr(ATEF_OFF_STATUS, 32'h0000_007F);
    rdr(ATEF_OFF_STATUS); `CHK(rd, 32'h0000_0000)
    $display("test software events done");
    wr(ATEF_OFF_CTRL, 32'h0000_0001);
    `CHK(ws, ATEF_RESP_OKAY)
    clr_seen(); wr(ATEF_OFF_SWEVT, 32'h0000_0001); settle(); `CHK(seen[4], 1'b0)
    clr_seen(); pulse(0); `CHK(seen[4], 1'b0)
    wr(ATEF_OFF_CTRL, 32'h0000_0002);
    clr_seen(); wr(ATEF_OFF_SWEVT, 32'h0000_0001); settle(); `CHK(seen[4], 1'b0)
    clr_seen(); pulse(0); `CHK(seen[4], 1'b1)
    rdr(ATEF_OFF_STATUS); `CHK(rd, 32'h0000_0001)
    wr(ATEF_OFF_CTRL, 32'h0000_0008);
    clr_seen(); wr(ATEF_OFF_SWEVT, 32'h0000_0040); settle(); `CHK(seen, 9'h150)
    wr(ATEF_OFF_CTRL, 32'h0000_000A);
    clr_seen(); wr(ATEF_OFF_SWEVT, 32'h0000_0040); settle(); `CHK(seen, 9'h140)
    $display("test overflow sources done");
    for (int i = 0; i < 6; i++) begin
      wr(ATEF_OFF_CTRL, {27'h0, tctl[i]});
      clr_seen();
      trg_in <= tlvl[i];
      settle();
      `CHK(seen[6], texp[i])
    end
    $display("test trigger edges done");
    wr(ATEF_OFF_CTRL, 32'h0000_0000);
    wr(ATEF_OFF_STATUS, 32'h0000_0000);
    wr(ATEF_OFF_CM1, 32'h0000_6075);
    @(posedge aclk);
    `CHK(is_in, 4'b0001)
    `CHK(out_ctrl, 12'h030)
    `CHK(in_filt, 16'h0007)
    cap_val <= 16'hA5C3;
    pulse(1);
    rdr(ATEF_OFF_STATUS); `CHK(rd, 32'h0000_0002)
    rdr(ATEF_OFF_C1DT); `CHK(rd, 32'h0000_A5C3)
    rdr(ATEF_OFF_STATUS); `CHK(rd, 32'h0000_0000)
    wstrb <= 4'h1;
    wr(ATEF_OFF_CM1, 32'h0000_00F4);
    wstrb <= 4'h3;
    rdr(ATEF_OFF_CM1); `CHK(rd, 32'h0000_60F4)
    `CHK(is_in, 4'b0000)
    `CHK(out_ctrl, 12'h037)
    `CHK(in_filt, 16'h0000)
    wr(ATEF_OFF_C1DT, 32'h0000_1234);
    pulse(2);
    rdr(ATEF_OFF_C1DT); `CHK(rd, 32'h0000_1234)
    `CHK(c1_cmp, 16'h1234)
    rdr(ATEF_OFF_STATUS); `CHK(rd, 32'h0000_0002)
    `CHK(flags, 8'h02)
    wr(ATEF_OFF_STATUS, 32'h0000_00FD);
    rdr(ATEF_OFF_STATUS); `CHK(rd, 32'h0000_0000)
    clr_seen(); pulse(3); `CHK(seen, 9'h080)
    rdr(ATEF_OFF_STATUS); `CHK(rd, 32'h0000_0080)
    `CHK(flags, 8'h80)
    $display("test channel one done");
    give_verdict();
  end

endmodule : atef_timer_events_tb_top

`default_nettype wire
